// >>> core/adcc_consts.svh
// Operation
// (R1) interrupts disabled: flag set per conversion, only the first in continuous mode
// (R2) writing status/control or reading result clears the completion flag
// (R3) interrupts enabled: flag bit reads back the pending converter request
// (R4) reset clears completion flag, interrupt enable and continuous bit
// (R5) interrupt enable set raises a request at each conversion end, else none
// (R6) reading result or writing status/control drops the request
// (R7) continuous bit repeats conversions; clear gives exactly one conversion
// (R8) channel codes 0-7 pick port B inputs, 8-14 pick port D inputs
// (R9) code 29 routes high reference, code 30 routes low reference
// (R10) all-ones channel code powers the converter down
// (R11) codes 15-26 and 28 give undefined results, 27 is reserved
// (R12) software waits one conversion after leaving power down
// (R13) one 8-bit result register loaded at every conversion end
// (R14) 3-bit prescaler divides by 1, 2, 4, 8, or 16 when top bit set
// (R15) source bit one picks bus clock, zero oscillator; reset picks oscillator
// (R16) software aims the converter clock near 1 MHz
// (R17) software leaves clock settings alone during a conversion
// (R18) status/control write starts a 16 to 17 converter-clock conversion
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_SCR_ADDR   8'h38
`define ADCC_RES_ADDR   8'h3C
`define ADCC_CLK_ADDR   8'h40
`define ADCC_SCR_FLAG   7
`define ADCC_SCR_INTERRUPT_ENABLE_BIT   6
`define ADCC_SCR_CONTINUOUS_BIT   5
`define ADCC_CLK_SRC    4
`define ADCC_SCR_RST    8'h1F
`define ADCC_CLK_RST    8'h00
`define ADCC_CH_PWR     5'h1F
`define ADCC_CH_HREF    5'h1D
`define ADCC_CH_LREF    5'h1E
`define ADCC_CH_PORTD   5'h08
`define ADCC_CH_LAST    5'h0E
`define ADCC_CONV_TICKS 4'hF
`endif

// >>> core/adcc_pkg.sv
`default_nettype none
package adcc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_CONV = 3'b100
  } state_type;
  typedef struct packed {
    logic       interrupt_enable_bit;
    logic       continuous_bit;
    logic [4:0] chan;
  } scr_type;
  typedef struct packed {
    logic [2:0] presc;
    logic       src;
  } clk_type;
endpackage
`default_nettype wire

// >>> core/adcc_regs.sv
// The implementer's own choice: the Wishbone register port.
`include "adcc_consts.svh"
`default_nettype none
module adcc_regs (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // analog core
  input  wire logic        OSC_CLK_I,
  input  wire logic [7:0]  ANA_DATA_I,
  output logic             ANA_STEP_O,
  output logic             ANA_BUSY_O,
  output logic             ANA_PWR_DOWN_O,
  output logic             ANA_REF_HIGH_O,
  output logic             ANA_REF_LOW_O,
  output logic      [7:0]  PORT_B_SEL_O,
  output logic      [6:0]  PORT_D_SEL_O,
  // converter request
  output logic             ADC_IRQ_O
);

  adcc_pkg::scr_type   scr_reg;
  adcc_pkg::clk_type   clk_reg;
  adcc_pkg::state_type state_reg;
  logic       flag_reg;
  logic       irq_reg;
  logic       first_reg;
  logic       ack_reg;
  logic [7:0] result_reg;
  logic [3:0] div_cnt_reg;
  logic [3:0] step_reg;
  logic       osc_prev_reg;
  logic [7:0] rd_data;
  logic       req;
  logic       wr_scr;
  logic       wr_clk;
  logic       rd_res;
  logic       src_tick;
  logic       adc_tick;
  logic       done;
  logic       clr;
  logic [3:0] div_max;
  // reset image of the clock register, sliced below for its upper nibble
  localparam logic [7:0] clk_rst_val = `ADCC_CLK_RST;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // terminal count of the prescaler for a field value
  function automatic logic [3:0] div_last(input logic [2:0] p);
    unique case (p)
      3'b000:  div_last = 4'h0;
      3'b001:  div_last = 4'h1;
      3'b010:  div_last = 4'h3;
      3'b011:  div_last = 4'h7;
      default: div_last = 4'hF;
    endcase
  endfunction

  assign req    = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign wr_scr = req & WB_WE_I & WB_SEL_I[0] & hit(WB_ADR_I, `ADCC_SCR_ADDR);
  assign wr_clk = req & WB_WE_I & WB_SEL_I[0] & hit(WB_ADR_I, `ADCC_CLK_ADDR);
  assign rd_res = req & ~WB_WE_I & hit(WB_ADR_I, `ADCC_RES_ADDR);
  assign clr    = wr_scr | rd_res;                             // [R2] [R6]

  always_comb begin
    rd_data = 8'h00;
    if (hit(WB_ADR_I, `ADCC_SCR_ADDR)) begin
      // flag bit shows pending request while interrupts are on
      rd_data = {scr_reg.interrupt_enable_bit ? irq_reg : flag_reg, scr_reg}; // [R3]
    end else if (hit(WB_ADR_I, `ADCC_RES_ADDR)) begin
      rd_data = result_reg;
    end else if (hit(WB_ADR_I, `ADCC_CLK_ADDR)) begin
      rd_data = {clk_reg, 4'h0};
    end
  end

  // one wait state; unmapped addresses are acked with zero data
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ack_reg  <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      ack_reg  <= req;
      WB_DAT_O <= req ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end
  assign WB_ACK_O = ack_reg;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      scr_reg <= adcc_pkg::scr_type'(7'(`ADCC_SCR_RST));      // [R4]
    end else if (wr_scr) begin
      scr_reg <= adcc_pkg::scr_type'(WB_DAT_I[6:0]);
    end
  end

  // no interlock against changes mid-conversion; software keeps off
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      clk_reg <= adcc_pkg::clk_type'(clk_rst_val[7:4]);       // [R15]
    end else if (wr_clk) begin
      clk_reg <= adcc_pkg::clk_type'(WB_DAT_I[7:4]);          // [R17]
    end
  end

  // oscillator input is sampled, so it must run below half the bus rate
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= OSC_CLK_I;
    end
  end
  assign src_tick = clk_reg.src | (OSC_CLK_I & ~osc_prev_reg); // [R15]
  assign div_max  = div_last(clk_reg.presc);
  assign adc_tick = src_tick & (div_cnt_reg >= div_max);        // [R14]

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      div_cnt_reg <= 4'h0;
    end else if (src_tick) begin
      div_cnt_reg <= adc_tick ? 4'h0 : div_cnt_reg + 4'h1;     // [R14] [R16]
    end
  end

  assign done = (state_reg == adcc_pkg::ST_CONV) & adc_tick
              & (step_reg == `ADCC_CONV_TICKS);

  // first tick aligns to the converter clock, giving 16 to 17 periods
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_reg <= adcc_pkg::ST_IDLE;
      step_reg  <= 4'h0;
    end else if (wr_scr) begin
      step_reg  <= 4'h0;
      if (WB_DAT_I[4:0] == `ADCC_CH_PWR) begin
        state_reg <= adcc_pkg::ST_IDLE;                        // [R10]
      end else begin
        state_reg <= adcc_pkg::ST_SYNC;                        // [R18]
      end
    end else begin
      unique case (state_reg)
        adcc_pkg::ST_IDLE: begin
          step_reg <= 4'h0;
        end
        adcc_pkg::ST_SYNC: begin
          if (adc_tick) begin
            state_reg <= adcc_pkg::ST_CONV;
          end
        end
        adcc_pkg::ST_CONV: begin
          if (adc_tick) begin
            step_reg <= step_reg + 4'h1;
            if (done && !scr_reg.continuous_bit) begin
              state_reg <= adcc_pkg::ST_IDLE;                  // [R7]
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      result_reg <= 8'h00;
    end else if (done) begin
      result_reg <= ANA_DATA_I;                                // [R13] [R7]
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      first_reg <= 1'b0;
    end else if (wr_scr) begin
      first_reg <= 1'b1;
    end else if (done) begin
      first_reg <= 1'b0;
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      flag_reg <= 1'b0;                                        // [R4]
    end else if (done && !scr_reg.interrupt_enable_bit && first_reg) begin
      flag_reg <= 1'b1;                                        // [R1]
    end else if (clr) begin
      flag_reg <= 1'b0;                                        // [R2]
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      irq_reg <= 1'b0;
    end else if (done && scr_reg.interrupt_enable_bit) begin
      irq_reg <= 1'b1;                                         // [R5]
    end else if (clr) begin
      irq_reg <= 1'b0;                                         // [R6]
    end
  end
  assign ADC_IRQ_O = irq_reg;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ANA_STEP_O <= 1'b0;
      ANA_BUSY_O <= 1'b0;
    end else begin
      ANA_STEP_O <= (state_reg == adcc_pkg::ST_CONV) & adc_tick;
      ANA_BUSY_O <= (state_reg != adcc_pkg::ST_IDLE);
    end
  end

  // unused and reserved codes select nothing; result is undefined
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ANA_PWR_DOWN_O <= 1'b1;
      ANA_REF_HIGH_O <= 1'b0;
      ANA_REF_LOW_O  <= 1'b0;
    end else begin
      ANA_PWR_DOWN_O <= (scr_reg.chan == `ADCC_CH_PWR);        // [R10] [R12]
      ANA_REF_HIGH_O <= (scr_reg.chan == `ADCC_CH_HREF);       // [R9]
      ANA_REF_LOW_O  <= (scr_reg.chan == `ADCC_CH_LREF);       // [R9] [R11]
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_port_b
      always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
          PORT_B_SEL_O[g] <= 1'b0;
        end else begin
          PORT_B_SEL_O[g] <= (scr_reg.chan == 5'(g));          // [R8]
        end
      end
    end
    for (g = 0; g < 7; g++) begin : g_port_d
      always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
          PORT_D_SEL_O[g] <= 1'b0;
        end else begin
          PORT_D_SEL_O[g] <= (scr_reg.chan == 5'(g + 8));      // [R8]
        end
      end
    end
  endgenerate

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  property p_flag_set;
    done && !scr_reg.interrupt_enable_bit && first_reg |=> flag_reg ##1 (flag_reg || $past(clr));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // [R1]

  property p_flag_clr;
    clr && !done |=> !flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared"); // [R2]

  property p_flag_read;
    req && hit(WB_ADR_I, `ADCC_SCR_ADDR)
      |=> WB_DAT_O[7] == $past(scr_reg.interrupt_enable_bit ? irq_reg : flag_reg);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag readback wrong"); // [R3]

  property p_irq_set;
    done && scr_reg.interrupt_enable_bit |=> ADC_IRQ_O;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("request missing"); // [R5]

  property p_irq_none;
    !scr_reg.interrupt_enable_bit |=> !$rose(ADC_IRQ_O);
  endproperty
  a_irq_none: assert property (p_irq_none) else $error("request while disabled"); // [R5]

  property p_irq_drop;
    rd_res && !done |=> !ADC_IRQ_O;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request not dropped"); // [R6]

  property p_single;
    done && !scr_reg.continuous_bit && !wr_scr |=> state_reg == adcc_pkg::ST_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single mode kept going"); // [R7]

  property p_port_b;
    ##1 PORT_B_SEL_O == (($past(scr_reg.chan) < 5'h08) ? 8'h01 << $past(scr_reg.chan[2:0])
                                                        : 8'h00);
  endproperty
  a_port_b: assert property (p_port_b) else $error("port select wrong"); // [R8]

  property p_pwr;
    ##1 ANA_PWR_DOWN_O == ($past(scr_reg.chan) == `ADCC_CH_PWR);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power down wrong"); // [R10]

  property p_result;
    done |=> result_reg == $past(ANA_DATA_I);
  endproperty
  a_result: assert property (p_result) else $error("result not loaded"); // [R13]

  property p_div1;
    clk_reg.src && clk_reg.presc == 3'b000 |-> adc_tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one broken"); // [R14]

  c_single: cover property (done && !scr_reg.continuous_bit);
  c_cont:   cover property (done && scr_reg.continuous_bit && !first_reg);
  c_irq:    cover property ($rose(ADC_IRQ_O));
  c_race:   cover property (done && clr);

endmodule
`default_nettype wire

// >>> testbench/adcc_cpu_model.sv
`default_nettype none
module adcc_cpu_model (
  // bus side
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  // one classic cycle; a missing ack is cut by the bench timeout
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= wr;
    adr_o <= adr;
    sel_o <= 4'h1;
    dat_o <= {24'h00_0000, wd};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released data is scrambled so a stale value cannot pass
    dat_o <= ~dat_o;
  endtask
endmodule
`default_nettype wire

// >>> testbench/adc_control_registers_bench.sv
`default_nettype none
module adc_control_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, osc, cyc, stb, we, ack, step, busy, pwr, refh, refl, irq;
  logic [7:0]  ana, adr, pb, q, dmy;
  logic [6:0]  pd;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  integer      fails, checks, cycles, seed, k, n, ch, d, steps, st;

  adcc_regs u_adcc_regs (
    .REF_CLK_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .OSC_CLK_I(osc), .ANA_DATA_I(ana), .ANA_STEP_O(step), .ANA_BUSY_O(busy),
    .ANA_PWR_DOWN_O(pwr), .ANA_REF_HIGH_O(refh), .ANA_REF_LOW_O(refl),
    .PORT_B_SEL_O(pb), .PORT_D_SEL_O(pd), .ADC_IRQ_O(irq));
  adcc_cpu_model u_adcc_cpu_model (
    .clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    u_adcc_cpu_model.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_adcc_cpu_model.xfer(1'b1, a, v, dmy);
  endtask
  task automatic settle(input integer c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  // expected {port D, port B} one-hot select for a channel code
  function automatic logic [14:0] exp_sel(input integer c);
    exp_sel = (c < 15) ? 15'h0001 << c : 15'h0000;
  endfunction

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // oscillator at a quarter of the bus rate, well inside the sampling limit
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles[0]) begin
      osc <= ~osc;
    end
    if (step === 1'b1) begin
      steps = steps + 1;
    end
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  initial begin
    rst = 1'b1;
    ana = 8'h00;
    osc = 1'b0;
    steps = 0;
    fails = 0;
    checks = 0;
    cycles = 0;
    seed = 32'h22ea_b66f;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle(0);
    check("pwr_down", pwr, 1);
    rd(8'h38); check("scr_reset", q, 8'h1F);
    rd(8'h40); check("clk_reset", q, 8'h00);
    rd(8'h44); check("unmapped", q, 8'h00);
    // first conversion after power-up only settles the analog side
    wr(8'h38, 8'h00);
    repeat (200) @(posedge clk);
    for (k = 0; k < 4; k++) begin
      ch = $unsigned($random(seed)) % 15;
      wr(8'h38, ch[7:0]);
      ana <= $random(seed);
      settle(0);
      check("chan_sel", {pd, pb}, exp_sel(ch));
      settle(200);
      rd(8'h38); check("flag_set", q, 8'h80 | ch[7:0]);
      check("no_irq", irq, 0);
      rd(8'h3C); check("result", q, ana);
      rd(8'h38); check("flag_rd_clr", q[7], 0);
    end
    for (k = 0; k < 8; k++) begin
      d = (k >= 4) ? 16 : (1 << k);
      // bus source; settings change only while idle
      wr(8'h40, {k[2:0], 5'h10});
      ch = $unsigned($random(seed)) % 15;
      st = steps;
      wr(8'h38, 8'h40 | ch[7:0]);
      ana <= $random(seed);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge clk);
        n = n + 1;
      end
      check("conv_time", (n >= 16 * d && n <= 17 * d + 3), 1);
      rd(8'h38); check("irq_bit", q[7], 1);
      check("step_count", steps - st, 16);
      if (k == 7) begin
        wr(8'h38, 8'h1D);
        settle(0);
        check("irq_wr_drop", {irq, refh, refl}, 3'b010);
      end else begin
        rd(8'h3C); check("irq_result", q, ana);
        settle(1);
        check("irq_rd_drop", irq, 0);
      end
    end
    settle(300);
    wr(8'h38, 8'h1E);
    settle(0);
    check("ref_low", {refh, refl, pd, pb}, 17'h0_8000);
    settle(300);
    wr(8'h38, 8'h0F);
    settle(0);
    check("unused_code", {pwr, refh, refl, pd, pb}, 18'h0_0000);
    settle(300);
    wr(8'h40, 8'h10);
    ana <= 8'hA5;
    wr(8'h38, 8'h23);
    settle(25);
    rd(8'h38); check("cont_flag", q, 8'hA3);
    ana <= 8'h5A;
    settle(25);
    rd(8'h3C); check("cont_result", q, 8'h5A);
    settle(40);
    rd(8'h38); check("cont_no_reflag", q[7], 0);
    settle(0);
    check("cont_busy", busy, 1);
    wr(8'h38, 8'h1F);
    settle(2);
    check("off_idle", {pwr, busy}, 2'b10);
    report_and_stop();
  end
endmodule
`default_nettype wire
